// ---- rtl/clock_mode_pkg.sv ----
`default_nettype none

package clock_mode_pkg;

    // ------------------------------------------------------------------
    // latch and mode field layout
    // ------------------------------------------------------------------
    localparam int              LATCH_W     = 8;
    localparam int              MODE_W      = 3;
    localparam int              MODE_MSB    = 7;
    localparam int              MODE_LSB    = 5;
    localparam logic [7:0]      LATCH_RESET = 8'hE0;   // mode 111, factor 4
    localparam logic [7:0]      INVERT_MASK = 8'h80;   // top pin in emulation

    // ------------------------------------------------------------------
    // clock mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0]      MODE_X4       = 3'h7;
    localparam logic [2:0]      MODE_X3       = 3'h6;
    localparam logic [2:0]      MODE_X2       = 3'h5;
    localparam logic [2:0]      MODE_X5       = 3'h4;
    localparam logic [2:0]      MODE_DIRECT   = 3'h3;
    localparam logic [2:0]      MODE_X1P5     = 3'h2;
    localparam logic [2:0]      MODE_PRESCALE = 3'h1;
    localparam logic [2:0]      MODE_X2P5     = 3'h0;

    // ------------------------------------------------------------------
    // pll windows: oscillator transitions per resync, cpu edges per window
    // ------------------------------------------------------------------
    localparam int              WIN_W   = 4;
    localparam int              EDGE_W  = 5;
    localparam logic [3:0]      WIN_X4  = 4'h4;
    localparam logic [3:0]      WIN_X3  = 4'h3;
    localparam logic [3:0]      WIN_X2  = 4'h2;
    localparam logic [3:0]      WIN_X5  = 4'h5;
    localparam logic [3:0]      WIN_HALF = 4'h2;       // for 1.5 and 2.5
    localparam logic [4:0]      EDGES_X4   = 5'h10;
    localparam logic [4:0]      EDGES_X3   = 5'h09;
    localparam logic [4:0]      EDGES_X2   = 5'h04;
    localparam logic [4:0]      EDGES_X5   = 5'h19;
    localparam logic [4:0]      EDGES_X1P5 = 5'h03;
    localparam logic [4:0]      EDGES_X2P5 = 5'h05;

    // ------------------------------------------------------------------
    // pll counters
    // ------------------------------------------------------------------
    localparam int              CNT_W    = 12;
    localparam int              ACC_W    = 13;
    localparam logic [11:0]     LEN_INIT = 12'h050;
    localparam logic [11:0]     LEN_STEP = 12'h001;
    localparam logic [11:0]     CNT_MAX  = 12'hFFF;

    typedef enum logic [1:0] {
        GEN_PLL,
        GEN_PRESCALE,
        GEN_DIRECT
    } gen_e;

endpackage

`default_nettype wire

// ---- rtl/edge_pulse.sv ----
`timescale 1ns/100ps
`default_nettype none

module edge_pulse (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic level_in,
    output logic      level_q,
    output logic      rise_q,
    output logic      fall_q,
    output logic      edge_q
);

    // ------------------------------------------------------------------
    // registered level and one-cycle edge pulses
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
            fall_q  <= 1'b0;
            edge_q  <= 1'b0;
        end else begin
            level_q <= level_in;
            rise_q  <= level_in & ~level_q;
            fall_q  <= ~level_in & level_q;
            edge_q  <= level_in ^ level_q;
        end
    end

endmodule // edge_pulse

`default_nettype wire

// ---- rtl/cpu_clock_mode_select.sv ----
`timescale 1ns/100ps
`default_nettype none

module cpu_clock_mode_select
    import clock_mode_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         osc_in,
    input  wire logic         long_reset,
    input  wire logic [7:0]   port0_upper_byte,
    input  wire logic         emulation_mode,
    input  wire logic         emulation_hold_mode,
    input  wire logic         reload_strobe,
    input  wire logic [7:0]   reset_control_upper,
    output logic [7:0]        reset_config_latch_q,
    output logic [2:0]        clock_mode_q,
    output var gen_e          gen_mode_q,
    output logic              pll_enable_q,
    output logic              pll_resync_q,
    output logic              cpu_clk_q,
    output logic              cpu_rise_q,
    output logic              cpu_fall_q,
    output logic              cpu_step_q
);

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic [2:0]       mode_field;
    logic             invert_top;
    logic [7:0]       captured;
    logic             restart;
    gen_e             gen_d;
    logic [3:0]       win_d;
    logic [4:0]       edges_d;
    logic [3:0]       win_q;
    logic [4:0]       edges_q;
    logic             osc_level;
    logic             osc_rise;
    logic             osc_edge;
    logic [3:0]       trans_cnt_q;
    logic [11:0]      win_cyc_q;
    logic [11:0]      measured;
    logic             sync_now;
    logic [11:0]      len_q;
    logic [12:0]      acc_q;
    logic [12:0]      acc_sum;
    logic             nco_tick;

    assign mode_field = reset_config_latch_q[MODE_MSB:MODE_LSB];
    assign invert_top = emulation_mode | emulation_hold_mode;
    assign captured   = invert_top ? (port0_upper_byte ^ INVERT_MASK)
                                   : port0_upper_byte;
    assign restart    = (mode_field != clock_mode_q);

    // ------------------------------------------------------------------
    // reset configuration latch
    // ------------------------------------------------------------------
    // capture beats reload so the pins always win during a long reset
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reset_config_latch_q <= LATCH_RESET;
        end else if (long_reset) begin
            reset_config_latch_q <= captured;
        end else if (reload_strobe) begin
            reset_config_latch_q <= reset_control_upper;
        end
    end

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    always_comb begin
        gen_d   = GEN_PLL;
        win_d   = WIN_X4;
        edges_d = EDGES_X4;
        case (mode_field)
            MODE_X4: begin
                win_d   = WIN_X4;
                edges_d = EDGES_X4;
            end
            MODE_X3: begin
                win_d   = WIN_X3;
                edges_d = EDGES_X3;
            end
            MODE_X2: begin
                win_d   = WIN_X2;
                edges_d = EDGES_X2;
            end
            MODE_X5: begin
                win_d   = WIN_X5;
                edges_d = EDGES_X5;
            end
            // fractional factors need two transitions per resync window
            MODE_X1P5: begin
                win_d   = WIN_HALF;
                edges_d = EDGES_X1P5;
            end
            MODE_X2P5: begin
                win_d   = WIN_HALF;
                edges_d = EDGES_X2P5;
            end
            MODE_PRESCALE: begin
                gen_d = GEN_PRESCALE;
            end
            MODE_DIRECT: begin
                gen_d = GEN_DIRECT;
            end
            default: begin
                gen_d = GEN_PLL;
            end
        endcase
    end

    // registered copy of the field; only follows the latch
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clock_mode_q <= LATCH_RESET[MODE_MSB:MODE_LSB];
            gen_mode_q   <= GEN_PLL;
            pll_enable_q <= 1'b1;
            win_q        <= WIN_X4;
            edges_q      <= EDGES_X4;
        end else begin
            clock_mode_q <= mode_field;
            gen_mode_q   <= gen_d;
            pll_enable_q <= (gen_d == GEN_PLL);
            win_q        <= win_d;
            edges_q      <= edges_d;
        end
    end

    // ------------------------------------------------------------------
    // oscillator edges
    // ------------------------------------------------------------------
    edge_pulse osc_edges (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .level_in (osc_in),
        .level_q  (osc_level),
        .rise_q   (osc_rise),
        .fall_q   (),
        .edge_q   (osc_edge)
    );

    // ------------------------------------------------------------------
    // pll window measurement
    // ------------------------------------------------------------------
    // the window closes on the win_q-th oscillator transition
    assign sync_now = pll_enable_q & osc_edge & (trans_cnt_q == (win_q - 4'h1));
    assign measured = (win_cyc_q == CNT_MAX) ? CNT_MAX : win_cyc_q + LEN_STEP;

    always_ff @(posedge ref_clk) begin
        if (reset || restart || !pll_enable_q) begin
            trans_cnt_q  <= '0;
            win_cyc_q    <= '0;
            pll_resync_q <= 1'b0;
        end else begin
            pll_resync_q <= sync_now;
            if (sync_now) begin
                trans_cnt_q <= '0;
                win_cyc_q   <= '0;
            end else begin
                if (osc_edge) begin
                    trans_cnt_q <= trans_cnt_q + 4'h1;
                end
                if (win_cyc_q != CNT_MAX) begin
                    win_cyc_q <= win_cyc_q + LEN_STEP;
                end
            end
        end
    end

    // window length moves one step per resync, never a jump
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            len_q <= LEN_INIT;
        end else if (sync_now && !restart) begin
            if (measured > len_q) begin
                len_q <= len_q + LEN_STEP;
            end else if (measured < len_q) begin
                len_q <= len_q - LEN_STEP;
            end
        end
    end

    // ------------------------------------------------------------------
    // numerically controlled edge generator
    // ------------------------------------------------------------------
    // edges_q cpu edges spread evenly over len_q reference cycles
    assign acc_sum  = acc_q + {8'h00, edges_q};
    assign nco_tick = pll_enable_q & !restart & (acc_sum >= {1'b0, len_q});

    always_ff @(posedge ref_clk) begin
        if (reset || restart || !pll_enable_q) begin
            acc_q <= '0;
        end else if (nco_tick) begin
            acc_q <= acc_sum - {1'b0, len_q};
        end else begin
            acc_q <= acc_sum;
        end
    end

    // ------------------------------------------------------------------
    // cpu clock
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cpu_clk_q <= 1'b0;
        end else begin
            case (gen_mode_q)
                GEN_PLL: begin
                    if (nco_tick) begin
                        cpu_clk_q <= ~cpu_clk_q;
                    end
                end
                GEN_PRESCALE: begin
                    if (osc_rise) begin
                        cpu_clk_q <= ~cpu_clk_q;
                    end
                end
                GEN_DIRECT: begin
                    cpu_clk_q <= osc_level;
                end
                default: begin
                    cpu_clk_q <= cpu_clk_q;
                end
            endcase
        end
    end

    // both edges give timing steps to the rest of the core
    edge_pulse cpu_edges (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .level_in (cpu_clk_q),
        .level_q  (),
        .rise_q   (cpu_rise_q),
        .fall_q   (cpu_fall_q),
        .edge_q   (cpu_step_q)
    );

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence long_capture_s;
        long_reset;
    endsequence

    sequence quiet_s;
        !long_reset && !reload_strobe;
    endsequence

    latch_capture_a: assert property (long_capture_s |=> reset_config_latch_q ==
        (($past(emulation_mode) || $past(emulation_hold_mode)) ?
         ($past(port0_upper_byte) ^ INVERT_MASK) : $past(port0_upper_byte)))
        else $error("latch did not capture port pins");

    top_invert_a: assert property ((long_reset && emulation_hold_mode) |=>
        reset_config_latch_q[7] != $past(port0_upper_byte[7]))
        else $error("top pin not inverted in emulation hold");

    latch_reload_a: assert property ((reload_strobe && !long_reset) |=>
        reset_config_latch_q == $past(reset_control_upper))
        else $error("latch not reloaded from control register");

    latch_hold_a: assert property (quiet_s |=> $stable(reset_config_latch_q))
        else $error("latch changed without capture or reload");

    mode_field_a: assert property (1'b1 |=> clock_mode_q == $past(reset_config_latch_q[7:5]))
        else $error("mode field does not follow latch bits");

    pll_enable_a: assert property (1'b1 |=> pll_enable_q ==
        ($past(mode_field) != 3'h1 && $past(mode_field) != 3'h3))
        else $error("pll enable wrong for mode");

    factor_four_a: assert property ((mode_field == 3'h7) |=>
        (edges_q == 5'h10 && win_q == 4'h4))
        else $error("factor four window wrong");

    factor_half_a: assert property ((mode_field == 3'h2) |=>
        (edges_q == 5'h03 && win_q == 4'h2))
        else $error("factor one and a half window wrong");

    pll_smooth_a: assert property ($changed(len_q) |->
        (len_q == $past(len_q) + 12'h001 || len_q == $past(len_q) - 12'h001))
        else $error("pll period jumped");

    pll_tick_a: assert property ((gen_mode_q == GEN_PLL && nco_tick) |=>
        cpu_clk_q != $past(cpu_clk_q))
        else $error("pll tick did not toggle cpu clock");

    prescale_a: assert property ((gen_mode_q == GEN_PRESCALE && osc_rise) |=>
        cpu_clk_q != $past(cpu_clk_q) ##1 ((gen_mode_q != GEN_PRESCALE) || osc_rise ||
        $stable(cpu_clk_q)))
        else $error("prescaler toggled outside oscillator rise");

    direct_drive_a: assert property ((gen_mode_q == GEN_DIRECT) |=>
        cpu_clk_q == $past(osc_level))
        else $error("direct drive does not follow oscillator");

    cpu_edge_a: assert property ($rose(cpu_clk_q) |=> cpu_rise_q ##0 cpu_step_q)
        else $error("cpu rising edge pulse missing");

    cpu_step_a: assert property (cpu_step_q == (cpu_rise_q || cpu_fall_q))
        else $error("timing step not on both edges");

endmodule // cpu_clock_mode_select

`default_nettype wire

// ---- bench/osc_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// oscillator source with programmable high and low phase lengths
// ----------------------------------------------------------------------
module osc_model (
    input  wire logic       ref_clk,
    input  wire logic       run,
    input  wire logic [7:0] high_cycles,
    input  wire logic [7:0] low_cycles,
    output var  logic       osc_out
);
    logic [7:0] cnt_q;

    initial begin
        osc_out = 1'b0;
        cnt_q   = 8'h01;
    end

    // uneven phases on purpose so duty-cycle slips show up
    always @(posedge ref_clk) begin
        if (!run) begin
            osc_out <= 1'b0;
            cnt_q   <= 8'h01;
        end else if (cnt_q >= (osc_out ? high_cycles : low_cycles)) begin
            osc_out <= ~osc_out;
            cnt_q   <= 8'h01;
        end else begin
            cnt_q   <= cnt_q + 8'h01;
        end
    end
endmodule // osc_model

`default_nettype wire

// ---- bench/cpu_clock_mode_select_bench.sv ----
`timescale 1ns/100ps
`default_nettype none

module cpu_clock_mode_select_bench;
    import clock_mode_pkg::*;

    logic       ref_clk, reset, osc_in, long_reset, emulation_mode, emulation_hold_mode, reload_strobe;
    logic [7:0] port0_upper_byte, reset_control_upper, latch_q, osc_hi, osc_lo;
    logic [2:0] clock_mode_q;
    gen_e       gen_mode_q;
    logic       pll_enable_q, pll_resync_q, cpu_clk_q, cpu_rise_q, cpu_fall_q, cpu_step_q;
    logic       mon_on, dir_on, h1, h2, c1, c2;
    int         num_errors, num_checks, cyc, cnt_step, cnt_res, run_len, ph_last, ph_prev, a, b;
    integer     seed;
    logic [31:0] r;
    logic [2:0] pll_codes [6] = '{3'h4, 3'h7, 3'h6, 3'h5, 3'h2, 3'h0};

    cpu_clock_mode_select cpu_clock_mode_select_i (.ref_clk(ref_clk), .reset(reset), .osc_in(osc_in),
        .long_reset(long_reset), .port0_upper_byte(port0_upper_byte), .emulation_mode(emulation_mode),
        .emulation_hold_mode(emulation_hold_mode), .reload_strobe(reload_strobe),
        .reset_control_upper(reset_control_upper), .reset_config_latch_q(latch_q),
        .clock_mode_q(clock_mode_q), .gen_mode_q(gen_mode_q), .pll_enable_q(pll_enable_q),
        .pll_resync_q(pll_resync_q), .cpu_clk_q(cpu_clk_q), .cpu_rise_q(cpu_rise_q),
        .cpu_fall_q(cpu_fall_q), .cpu_step_q(cpu_step_q));

    osc_model osc_model_i (.ref_clk(ref_clk), .run(1'b1), .high_cycles(osc_hi), .low_cycles(osc_lo),
        .osc_out(osc_in));

    always #5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // expectation helpers and reporting
    // ------------------------------------------------------------------
    function automatic gen_e exp_gen(input logic [2:0] c);
        return (c == MODE_PRESCALE) ? GEN_PRESCALE : (c == MODE_DIRECT) ? GEN_DIRECT : GEN_PLL;
    endfunction

    // cpu edges in 20 oscillator transitions, that is 10 periods
    function automatic int edges20(input logic [2:0] c);
        case (c)
            3'h7: return 80;
            3'h6: return 60;
            3'h5: return 40;
            3'h4: return 100;
            3'h2: return 30;
            default: return 50;
        endcase
    endfunction

    function automatic int win(input logic [2:0] c);
        return (c == 3'h7) ? 4 : (c == 3'h6) ? 3 : (c == 3'h4) ? 5 : 2;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic near(input string name, input int exp, input int got, input int tol);
        num_checks++;
        if (got < exp - tol || got > exp + tol) begin
            num_errors++;
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one capture or reload, then the latch and the decoded mode chain
    task automatic load(input logic lr, input logic rs, input logic [7:0] pins, input logic [7:0] data,
                        input logic em, input logic eh);
        logic [7:0] e;
        e = lr ? (pins ^ ((em | eh) ? INVERT_MASK : 8'h00)) : data;
        @(posedge ref_clk);
        long_reset          <= lr;
        reload_strobe       <= rs;
        port0_upper_byte    <= pins;
        reset_control_upper <= data;
        emulation_mode      <= em;
        emulation_hold_mode <= eh;
        @(posedge ref_clk);
        long_reset    <= 1'b0;
        reload_strobe <= 1'b0;
        #1 chk("latch", {24'h0, e}, {24'h0, latch_q});
        @(posedge ref_clk);
        #1 chk("clock_mode", {29'h0, e[MODE_MSB:MODE_LSB]}, {29'h0, clock_mode_q});
        chk("gen_mode", {30'h0, exp_gen(e[7:5])}, {30'h0, gen_mode_q});
        chk("pll_enable", {31'h0, exp_gen(e[7:5]) == GEN_PLL}, {31'h0, pll_enable_q});
    endtask

    // ------------------------------------------------------------------
    // port monitor: edge pulses, direct delay, phase lengths, counts
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        h1 <= osc_in;
        h2 <= h1;
        c1 <= cpu_clk_q;
        c2 <= c1;
        if (mon_on) begin
            chk("cpu_rise", {31'h0, c1 & ~c2}, {31'h0, cpu_rise_q});
            chk("cpu_fall", {31'h0, ~c1 & c2}, {31'h0, cpu_fall_q});
            chk("cpu_step", {31'h0, c1 ^ c2}, {31'h0, cpu_step_q});
            if (dir_on)
                chk("cpu_clk", {31'h0, h2}, {31'h0, cpu_clk_q});
            if (cpu_step_q === 1'b1) cnt_step <= cnt_step + 1;
            if (pll_resync_q === 1'b1) cnt_res <= cnt_res + 1;
            if (cpu_clk_q !== c1) begin
                ph_prev <= ph_last;
                ph_last <= run_len;
                run_len <= 1;
            end else begin
                run_len <= run_len + 1;
            end
        end
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            $display("mismatch timeout expected finish seen hang");
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h9fe0;
        ref_clk = 1'b0; reset = 1'b1; long_reset = 1'b0; reload_strobe = 1'b0;
        port0_upper_byte = 8'h00; reset_control_upper = 8'h00;
        emulation_mode = 1'b0; emulation_hold_mode = 1'b0; osc_hi = 8'h14; osc_lo = 8'h14;
        mon_on = 1'b0; dir_on = 1'b0; c1 = 1'b0; c2 = 1'b0;
        num_errors = 0; num_checks = 0; cyc = 0; cnt_step = 0; cnt_res = 0; run_len = 0;
        repeat (3) @(posedge ref_clk);
        reset  <= 1'b0;
        mon_on <= 1'b1;
        #1 chk("latch_reset", {24'h0, LATCH_RESET}, {24'h0, latch_q});
        chk("mode_reset", 32'h7, {29'h0, clock_mode_q});
        chk("pll_reset", 32'h1, {31'h0, pll_enable_q});
        $display("test reset done");
        // every pin code, capture racing a reload at code 0 and on random codes; codes 5, 6, 7 force emulation, hold, neither
        for (int c = 0; c < 8; c++) begin
            r = $random(seed);
            load(1'b1, r[8] | (c == 0), {c[2:0], r[4:0]}, r[23:16],
                 (c == 5) | (r[9] & (c < 6)), (c == 6) | (r[10] & (c < 5)));
        end
        r = $random(seed);
        load(1'b0, 1'b1, r[7:0], r[15:8], 1'b1, 1'b1);
        $display("test capture and reload done");
        a = latch_q;
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            @(posedge ref_clk);
            port0_upper_byte    <= r[7:0];
            reset_control_upper <= r[15:8];
            emulation_mode      <= r[16];
        end
        repeat (2) @(posedge ref_clk);
        #1 chk("latch_hold", a, {24'h0, latch_q});
        $display("test hold done");
        // direct drive with an uneven duty cycle
        osc_hi <= 8'h03;
        osc_lo <= 8'h05;
        load(1'b0, 1'b1, 8'h00, {MODE_DIRECT, 5'h0A}, 1'b0, 1'b0);
        repeat (4) @(posedge ref_clk);
        dir_on <= 1'b1;
        repeat (64) @(posedge ref_clk);
        dir_on <= 1'b0;
        #1 chk("direct_two_phases", 32'd8, ph_last + ph_prev);
        $display("test direct done");
        osc_hi <= 8'h02;
        osc_lo <= 8'h04;
        load(1'b0, 1'b1, 8'h00, {MODE_PRESCALE, 5'h15}, 1'b0, 1'b0);
        repeat (60) @(posedge ref_clk);
        #1 chk("prescale_phase", 32'd6, ph_last);
        chk("prescale_prev", 32'd6, ph_prev);
        $display("test prescale done");
        // pll factors on a 40-cycle oscillator; first the slow lock, then counts
        osc_hi <= 8'h14;
        osc_lo <= 8'h14;
        foreach (pll_codes[k]) begin
            r = $random(seed);
            load(1'b0, 1'b1, 8'h00, {pll_codes[k], r[4:0]}, 1'b0, 1'b0);
            repeat (2500) @(posedge ref_clk);
            a = cnt_step;
            b = cnt_res;
            repeat (400) @(posedge ref_clk);
            near("pll_edges", edges20(pll_codes[k]), cnt_step - a, 2);
            near("pll_resync", 20 / win(pll_codes[k]), cnt_res - b, 1);
        end
        $display("test pll done");
        end_of_test();
    end
endmodule // cpu_clock_mode_select_bench

`default_nettype wire
